// ==== hw/adcf_pkg.sv ====
package adcf_pkg;
   // conversion and framing geometry
   localparam int         RES_BITS        = 12;
   localparam int         CTRL_BITS       = 8;
   localparam logic [3:0] START_OPEN_STEP = 4'h7;   // decisions out once bit five is shown
   // power-select field decode
   localparam logic [1:0] PD_DEEP         = 2'h0;
   localparam logic [1:0] PD_LIGHT        = 2'h1;
   localparam logic [1:0] PD_INT          = 2'h2;
   localparam logic [1:0] PD_EXT          = 2'h3;
   // reset values
   localparam logic       RST_EXT_MODE    = 1'b0;   // internal clock mode after reset
   localparam logic       RST_STROBE      = 1'b1;
   // internal conversion clock
   localparam int         MCLK_MHZ        = 100;
   localparam int         INT_STEP_NS     = 500;
   localparam int         INT_STEP_CYC    = (INT_STEP_NS * MCLK_MHZ) / 1000;
   localparam int         FIFO_DEPTH      = 32;

   // control byte as shifted in, first bit in the msb
   typedef struct packed {
      logic       start;
      logic [2:0] chan_sel;
      logic       unipolar;
      logic       single_end;
      logic       power_select_hi;
      logic       power_select_lo;
   } adcf_ctrl_type;

   // asynchronous pins, carried together through the synchroniser
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
      logic shutdown_pin;
      logic comp_float;
      logic cmp;
   } adcf_pins_type;

   typedef enum {CV_IDLE, CV_EXT, CV_INT} adcf_conv_type;
   typedef enum {PW_ACTIVE, PW_LIGHT, PW_DEEP} adcf_pwr_type;
endpackage : adcf_pkg

// ==== hw/adcf_ctrl.sv ====
// Summary of operation
// - select falling edge alone starts nothing
// - conversion launches on fall after eighth bit
// - idle: first one with select low starts
// - busy: start accepted after bit five shown
// - early forced start aborts and restarts conversion
// - overlapped external mode: fifteen clocks minimum
// - reset: internal clock mode, strobe high
// - zeros shifted out before first conversion
// - floating shutdown pin selects external compensation
// - low shutdown pin forces deep sleep always
// - sleep keeps interface, performs no conversion
// - power-down waits for current conversion end
// - internal mode result readable while asleep
// - start wakes; upper select bit keeps awake
// - hardware shutdown halts conversion at once
// - power-select bits decode four modes
// - result bits shift out msb first, falling edge
// - external mode: one decision per falling edge
// - internal mode strobe low while converting
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// result buffer: register array, extra pointer bit tells full from empty
module adcf_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
) (
   input  wire logic             mclk_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_r;
   logic [AW:0]      rd_r;

   assign in_ready_o  = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_r != rd_r;
   assign out_data_o  = mem_r[rd_r[AW-1:0]];

   // storage has no reset; only pointers need a defined state
   always_ff @(posedge mclk_i) begin
      if (in_valid_i && in_ready_o) begin
         mem_r[wr_r[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (in_valid_i && in_ready_o) wr_r <= wr_r + 1'b1;
         if (out_valid_o && out_ready_i) rd_r <= rd_r + 1'b1;
      end
   end
endmodule : adcf_fifo

////////////////////////////////////////////////////////////////////////////////
module adcf_ctrl #(
   parameter int RES_BITS   = adcf_pkg::RES_BITS,
   parameter int FIFO_DEPTH = adcf_pkg::FIFO_DEPTH
) (
   input  wire logic                  mclk_i,
   input  wire logic                  reset_i,
   input  wire logic                  cs_n_i,
   input  wire logic                  sclk_i,
   input  wire logic                  din_i,
   input  wire logic                  shutdown_pin_i,
   input  wire logic                  comp_float_i,
   input  wire logic                  cmp_i,
   output logic                       dout_o,
   output logic                       dout_oe_o,
   output logic                       conversion_strobe_o,
   output logic                       conversion_strobe_oe_o,
   output logic [RES_BITS-1:0]        dac_code_o,
   output adcf_pkg::adcf_ctrl_type    ctrl_byte_o,
   output logic                       ext_comp_o,
   output logic                       deep_sleep_o,
   output logic                       light_sleep_o,
   output logic                       busy_o,
   output logic [RES_BITS-1:0]        result_o,
   output logic                       result_valid_o,
   input  wire logic                  result_ready_i,
   output logic                       result_drop_o
);
   adcf_pkg::adcf_pins_type pin_m_r;
   adcf_pkg::adcf_pins_type pin_s_r;
   adcf_pkg::adcf_conv_type conv_r;
   adcf_pkg::adcf_pwr_type  pwr_r;
   adcf_pkg::adcf_pwr_type  pend_pwr_r;
   adcf_pkg::adcf_ctrl_type ctrl_r;
   logic                    sclk_d_r;
   logic                    cs_n_d_r;
   logic                    framing_r;
   logic [2:0]              bit_cnt_r;
   logic [7:0]              ctrl_sr_r;
   logic                    launch_pend_r;
   logic                    cs_forced_r;
   logic                    ext_mode_r;
   logic [3:0]              step_r;
   logic [RES_BITS-1:0]     trial_r;
   logic [RES_BITS-1:0]     sar_nxt;
   logic [RES_BITS-1:0]     out_sr_r;
   logic [RES_BITS-1:0]     result_r;
   logic                    push_r;
   logic                    push_ready;
   logic                    dout_r;
   logic                    strobe_r;
   logic                    drop_r;
   logic [15:0]             tick_cnt_r;
   logic                    seen_conv_r;
   logic                    sclk_rise;
   logic                    sclk_fall;
   logic                    cs_fall;
   logic                    hw_off;
   logic                    start_ok;
   logic                    start_take;
   logic                    launch;
   logic                    conv_ext;
   logic                    int_tick;
   logic                    decide;
   logic                    last_step;
   logic                    done;
   logic [3:0]              idx;

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchroniser for every pin; edges compare second and third flop
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pin_m_r  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, shutdown_pin: 1'b1,
                       comp_float: 1'b0, cmp: 1'b0};
         pin_s_r  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, shutdown_pin: 1'b1,
                       comp_float: 1'b0, cmp: 1'b0};
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         pin_m_r  <= '{cs_n: cs_n_i, sclk: sclk_i, din: din_i,
                       shutdown_pin: shutdown_pin_i, comp_float: comp_float_i, cmp: cmp_i};
         pin_s_r  <= pin_m_r;
         sclk_d_r <= pin_s_r.sclk;
         cs_n_d_r <= pin_s_r.cs_n;
      end
   end

   // serial clock edges only count while select is low
   assign sclk_rise  = pin_s_r.sclk && !sclk_d_r && !pin_s_r.cs_n;
   assign sclk_fall  = !pin_s_r.sclk && sclk_d_r && !pin_s_r.cs_n;
   assign cs_fall    = !pin_s_r.cs_n && cs_n_d_r;
   assign hw_off     = !pin_s_r.shutdown_pin;
   assign ext_comp_o = pin_s_r.comp_float;

   // start window: idle, bit five already out, or forced by select
   assign start_ok   = conv_r == adcf_pkg::CV_IDLE ||
                       step_r >= adcf_pkg::START_OPEN_STEP ||
                       cs_forced_r;
   assign start_take = sclk_rise && !framing_r && pin_s_r.din && start_ok;
   assign launch     = sclk_fall && launch_pend_r && !hw_off;
   // a power-down byte still converts, in the mode last selected
   assign conv_ext   = ctrl_sr_r[1] ? ctrl_sr_r[0] : ext_mode_r;

   ////////////////////////////////////////////////////////////////////////////
   // control byte framing; select high abandons a partial byte
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         framing_r     <= 1'b0;
         bit_cnt_r     <= 3'h0;
         ctrl_sr_r     <= 8'h00;
         launch_pend_r <= 1'b0;
      end else if (pin_s_r.cs_n) begin
         framing_r     <= 1'b0;
         launch_pend_r <= 1'b0;
      end else if (start_take) begin
         framing_r     <= 1'b1;
         bit_cnt_r     <= 3'h1;
         ctrl_sr_r     <= 8'h01;
         launch_pend_r <= 1'b0;
      end else if (sclk_rise && framing_r) begin
         ctrl_sr_r <= {ctrl_sr_r[6:0], pin_s_r.din};
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (bit_cnt_r == 3'h7) begin
            framing_r     <= 1'b0;
            launch_pend_r <= 1'b1;
         end
      end else if (sclk_fall) begin
         launch_pend_r <= 1'b0;
      end
   end

   // select edge during a conversion opens the start window; set wins
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         cs_forced_r <= 1'b0;
      end else if (cs_fall && conv_r != adcf_pkg::CV_IDLE) begin
         cs_forced_r <= 1'b1;
      end else if (start_take || conv_r == adcf_pkg::CV_IDLE) begin
         cs_forced_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal conversion clock: one enable pulse per step time
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         tick_cnt_r <= 16'h0000;
      end else if (conv_r != adcf_pkg::CV_INT || int_tick) begin
         tick_cnt_r <= 16'h0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
   end
   assign int_tick = tick_cnt_r == 16'(adcf_pkg::INT_STEP_CYC - 1);

   // successive approximation step; internal mode holds its last step
   // while the buffer is full, external mode cannot stall the host clock
   assign idx       = 4'(RES_BITS - 1) - step_r;
   assign last_step = step_r == 4'(RES_BITS - 1);
   assign decide    = !launch && ((conv_r == adcf_pkg::CV_EXT && sclk_fall) ||
                      (conv_r == adcf_pkg::CV_INT && int_tick && (!last_step || push_ready)));
   assign done      = decide && last_step;

   always_comb begin
      sar_nxt      = trial_r;
      sar_nxt[idx] = pin_s_r.cmp;
      if (idx != 4'h0) begin
         sar_nxt[idx - 4'h1] = 1'b1;
      end
   end

   // conversion sequencer
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         conv_r  <= adcf_pkg::CV_IDLE;
         step_r  <= 4'h0;
         trial_r <= '0;
      end else if (hw_off) begin
         conv_r  <= adcf_pkg::CV_IDLE;
         step_r  <= 4'h0;
      end else if (launch) begin
         // a launch over a running conversion replaces it
         conv_r  <= conv_ext ? adcf_pkg::CV_EXT : adcf_pkg::CV_INT;
         step_r  <= 4'h0;
         trial_r <= {1'b1, {(RES_BITS-1){1'b0}}};
      end else if (decide) begin
         trial_r <= sar_nxt;
         step_r  <= done ? 4'h0 : step_r + 4'h1;
         if (done) conv_r <= adcf_pkg::CV_IDLE;
      end
   end
   assign dac_code_o = trial_r;
   assign busy_o     = conv_r != adcf_pkg::CV_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   // clock mode, control byte copy and power state
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ext_mode_r <= adcf_pkg::RST_EXT_MODE;
         ctrl_r     <= '0;
         pend_pwr_r <= adcf_pkg::PW_ACTIVE;
         pwr_r      <= adcf_pkg::PW_ACTIVE;
      end else begin
         if (launch) begin
            ctrl_r <= ctrl_sr_r;
            if (ctrl_sr_r[1]) ext_mode_r <= ctrl_sr_r[0];
            unique case (ctrl_sr_r[1:0])
               adcf_pkg::PD_DEEP:  pend_pwr_r <= adcf_pkg::PW_DEEP;
               adcf_pkg::PD_LIGHT: pend_pwr_r <= adcf_pkg::PW_LIGHT;
               adcf_pkg::PD_INT,
               adcf_pkg::PD_EXT:   pend_pwr_r <= adcf_pkg::PW_ACTIVE;
            endcase
         end
         if (hw_off) begin
            pwr_r <= adcf_pkg::PW_DEEP;
         end else if (start_take) begin
            pwr_r <= adcf_pkg::PW_ACTIVE;
         end else if (done) begin
            pwr_r <= pend_pwr_r;
         end
      end
   end
   assign ctrl_byte_o   = ctrl_r;
   assign deep_sleep_o  = pwr_r == adcf_pkg::PW_DEEP;
   assign light_sleep_o = pwr_r == adcf_pkg::PW_LIGHT;

   ////////////////////////////////////////////////////////////////////////////
   // conversion strobe: pulse in external mode, busy-low in internal mode
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         strobe_r <= adcf_pkg::RST_STROBE;
      end else if (launch) begin
         strobe_r <= conv_ext;
      end else if (hw_off || done) begin
         strobe_r <= !ext_mode_r;
      end else if (sclk_fall && ext_mode_r) begin
         strobe_r <= 1'b0;
      end
   end
   assign conversion_strobe_o    = strobe_r;
   // internal mode keeps driving the strobe with select high
   assign conversion_strobe_oe_o = !ext_mode_r || !pin_s_r.cs_n;

   // serial output: live decisions, else the stored result, msb first
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         dout_r   <= 1'b0;
         out_sr_r <= '0;
         result_r <= '0;
      end else begin
         if (done) result_r <= sar_nxt;
         if (done && conv_r == adcf_pkg::CV_INT) begin
            out_sr_r <= sar_nxt;
         end else if (decide && conv_r == adcf_pkg::CV_EXT) begin
            dout_r   <= pin_s_r.cmp;
            out_sr_r <= '0;
         end else if (sclk_fall) begin
            dout_r   <= out_sr_r[RES_BITS-1];
            out_sr_r <= {out_sr_r[RES_BITS-2:0], 1'b0};
         end
      end
   end
   assign dout_o    = dout_r;
   assign dout_oe_o = !pin_s_r.cs_n;

   ////////////////////////////////////////////////////////////////////////////
   // finished results into the buffer; external overflow is reported
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         push_r      <= 1'b0;
         drop_r      <= 1'b0;
         seen_conv_r <= 1'b0;
      end else begin
         push_r      <= done && push_ready;
         drop_r      <= done && !push_ready;
         seen_conv_r <= seen_conv_r || launch;
      end
   end
   assign result_drop_o = drop_r;

   adcf_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .in_valid_i  (push_r),
      .in_ready_o  (push_ready),
      .in_data_i   (result_r),
      .out_valid_o (result_valid_o),
      .out_ready_i (result_ready_i),
      .out_data_o  (result_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   start_gate_a: assert property (sclk_rise && !framing_r && !start_ok |=> !framing_r)
      else $error("start bit taken outside start window");
   launch_edge_a: assert property (launch |=> conv_r != adcf_pkg::CV_IDLE)
      else $error("no conversion after eighth bit");
   no_cs_start_a: assert property ($rose(busy_o) |-> $past(launch_pend_r))
      else $error("conversion started without control byte");
   hw_halt_a: assert property (hw_off |=> !busy_o && deep_sleep_o)
      else $error("shutdown did not halt conversion");
   int_strobe_a: assert property (conv_r == adcf_pkg::CV_INT |-> !conversion_strobe_o)
      else $error("strobe high during internal conversion");
   ext_pulse_a: assert property (conv_r == adcf_pkg::CV_EXT && sclk_fall && !launch
                                 |=> !conversion_strobe_o)
      else $error("external strobe longer than one clock");
   dout_zero_a: assert property (!seen_conv_r |-> !dout_o)
      else $error("nonzero output before first conversion");
   wake_up_a: assert property (start_take && !hw_off |=> pwr_r == adcf_pkg::PW_ACTIVE)
      else $error("start bit did not wake");
   sleep_after_a: assert property (done && !hw_off && pend_pwr_r == adcf_pkg::PW_DEEP
                                   |=> deep_sleep_o ##1 !busy_o)
      else $error("deep sleep not entered after conversion");
   cross_wake_a: assert property (hw_off [*2] |-> !busy_o && !launch)
      else $error("conversion under hardware shutdown");

   ext_done_c: cover property (done && conv_r == adcf_pkg::CV_EXT);
   int_done_c: cover property (done && conv_r == adcf_pkg::CV_INT);
   overlap_c:  cover property (start_take && conv_r == adcf_pkg::CV_EXT);
   stall_c:    cover property (conv_r == adcf_pkg::CV_INT && last_step && !push_ready);
endmodule : adcf_ctrl

`default_nettype wire

// ==== verification/adcf_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// host serial port: drives select, clock and data, samples result bits
module adcf_host_model (
   output var logic cs_n_o,
   output var logic sclk_o,
   output var logic din_o,
   input  wire logic dout_i
);
   // idle bus: select high, clock parked low between frames
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o  = 1'b0;
   end

   // one frame, msb first; data sampled on our rising edge, after the device's fall
   task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
      rx = '0;
      cs_n_o = 1'b0;
      // odd offset keeps every pin edge clear of the device clock edges
      #123;
      for (int i = 0; i < n; i++) begin
         din_o = tx[39-i];
         #63 sclk_o = 1'b1;
         rx[39-i] = dout_i;
         #62 sclk_o = 1'b0;
      end
      #250 cs_n_o = 1'b1;
      din_o = ~din_o; // ignored line flips so a stale level never looks valid
      // select stays high a while, so back-to-back frames show a falling edge
      #127;
   endtask : xfer
endmodule : adcf_host_model

`default_nettype wire

// ==== verification/adcf_ctrl_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module adcf_ctrl_tb_top;
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [11:0] vin;
      logic [1:0]  slp;
   } adcf_row_type;
   logic                    mclk, reset, cs_n, sclk, din, shut_pin, cfloat, rdy, cmp;
   logic                    dout, dout_oe, strobe, strobe_oe, ext_comp, deep, light;
   logic                    busy, rvalid, drop;
   logic [11:0]             vin, dac, rword;
   logic [39:0]             rx;
   logic [11:0]             got[$];
   int                      errors, checked, drops;
   adcf_pkg::adcf_ctrl_type cbyte;
   // ordinary frames: control byte, analog input, expected {deep, light}
   adcf_row_type rows[6] = '{'{8'hFF, 12'h000, 2'h0}, '{8'h8F, 12'hFFF, 2'h0},
      '{8'h8F, 12'hA5A, 2'h0}, '{8'h8D, 12'h801, 2'h1}, '{8'h8C, 12'h3C4, 2'h2},
      '{8'h8F, 12'h123, 2'h0}};

   adcf_ctrl uut (.mclk_i(mclk), .reset_i(reset), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
      .shutdown_pin_i(shut_pin), .comp_float_i(cfloat), .cmp_i(cmp), .dout_o(dout),
      .dout_oe_o(dout_oe), .conversion_strobe_o(strobe), .conversion_strobe_oe_o(strobe_oe),
      .dac_code_o(dac), .ctrl_byte_o(cbyte), .ext_comp_o(ext_comp), .deep_sleep_o(deep),
      .light_sleep_o(light), .busy_o(busy), .result_o(rword), .result_valid_o(rvalid),
      .result_ready_i(rdy), .result_drop_o(drop));
   // a released data line reads as the inverse of its last level
   adcf_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
      .dout_i(dout_oe ? dout : ~dout));

   // ideal comparator: the search should settle on the input code itself
   assign cmp = (vin >= dac);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // collect every word taken from the result stream, count lost words
   always @(posedge mclk) begin
      if (rvalid === 1'b1 && rdy === 1'b1) got.push_back(rword);
      if (drop === 1'b1) drops++;
   end

   task automatic chk_bit(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: flag got %b expected %b", $time, g, e);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [11:0] g, input logic [11:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: word got %h expected %h", $time, g, e);
      end
   endtask : chk_word

   function automatic logic [11:0] pop_got();
      if (got.size() == 0) return 'x;
      return got.pop_front();
   endfunction : pop_got

   // 24-clock frame: byte in, leading zero, result msb first, trailing zeros
   task automatic frame(input logic [7:0] c, input logic [11:0] v);
      vin = v;
      host.xfer({c, 32'h0}, 24, rx);
      repeat (6) @(negedge mclk);
      chk_word(rx[30:19], v);
      chk_word({rx[39:31], rx[18:16]}, 12'h000);
   endtask : frame

   // bounded wait for the internal-mode strobe to come back high
   task automatic wait_strobe();
      for (int k = 0; k < 800 && strobe !== 1'b1; k++) @(negedge mclk);
      chk_bit(strobe, 1'b1);
      repeat (4) @(negedge mclk);
   endtask : wait_strobe

   task automatic final_report();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // hang guard, well beyond the expected run length
   initial begin
      #600000;
      errors++;
      final_report();
   end

   initial begin
      {reset, shut_pin, cfloat, rdy, vin, errors, checked, drops} = {4'hF, 12'h000, 96'h0};
      repeat (12) @(negedge mclk);
      reset = 1'b0;
      repeat (20) @(negedge mclk);
      foreach (rows[i]) begin
         frame(rows[i].ctrl, rows[i].vin);
         chk_word(pop_got(), rows[i].vin);
         chk_word({4'h0, cbyte}, {4'h0, rows[i].ctrl});
         chk_word({10'h0, deep, light}, {10'h0, rows[i].slp});
         // scaled settle time after a sleep before the next request
         if (rows[i].slp != 2'h0) repeat (50) @(negedge mclk);
      end
      $display("test table done");
      // byte-wide host: next byte overlaps the previous result's tail
      vin = 12'h5A3;
      host.xfer({8'h8F, 8'h00, 8'h8F, 16'h0}, 40, rx);
      repeat (6) @(negedge mclk);
      chk_word(rx[30:19], 12'h5A3);
      chk_word(rx[14:3], 12'h5A3);
      chk_word(pop_got(), 12'h5A3);
      chk_word(pop_got(), 12'h5A3);
      // select pulse before bit five forces a start and drops the old word
      host.xfer({8'h8F, 32'h0}, 12, rx);
      // old decisions keep coming out until the new byte launches
      vin = 12'h9E7;
      host.xfer({8'h8F, 32'h0}, 24, rx);
      repeat (6) @(negedge mclk);
      chk_word(rx[30:19], 12'h9E7);
      chk_word({9'h0, rx[18:16]}, 12'h000);
      chk_word(pop_got(), 12'h9E7);
      chk_word(12'(got.size()), 12'h000);
      $display("test overlap and abort done");
      // internal clock, then a power-down byte still converting internally
      vin = 12'h6B1;
      host.xfer({8'h8E, 32'h0}, 8, rx);
      chk_bit(strobe, 1'b0);
      wait_strobe();
      chk_word(pop_got(), 12'h6B1);
      vin = 12'h2CE;
      host.xfer({8'h8C, 32'h0}, 8, rx);
      wait_strobe();
      chk_word(pop_got(), 12'h2CE);
      chk_bit(deep, 1'b1);
      // stored result still shifts out while asleep, msb on the first fall
      host.xfer(40'h0, 16, rx);
      chk_word(rx[38:27], 12'h2CE);
      $display("test internal mode done");
      // shutdown pin dropped mid-conversion, then a frame while held low
      fork
         host.xfer({8'h8F, 32'h0}, 24, rx);
         begin
            #1500 @(negedge mclk);
            shut_pin = 1'b0;
            repeat (6) @(negedge mclk);
            chk_bit(busy, 1'b0);
            chk_bit(deep, 1'b1);
         end
      join
      frame(8'h8F, 12'h000);
      chk_bit(busy, 1'b0);
      chk_word(12'(got.size()), 12'h000);
      {shut_pin, cfloat} = 2'h2;
      repeat (6) @(negedge mclk);
      chk_bit(ext_comp, 1'b0);
      // compensation input high selects external compensation
      cfloat = 1'b1;
      repeat (6) @(negedge mclk);
      chk_bit(ext_comp, 1'b1);
      $display("test shutdown done");
      // stalled reader: buffer fills, one word is lost, then drains in order
      rdy = 1'b0;
      for (int i = 0; i < 33; i++) frame(8'h8F, 12'h100 + 12'(i));
      chk_bit(rvalid, 1'b1);
      chk_word(12'(drops), 12'h001);
      rdy = 1'b1;
      repeat (40) @(negedge mclk);
      chk_word(12'(got.size()), 12'h020);
      for (int i = 0; i < 32; i++) chk_word(pop_got(), 12'h100 + 12'(i));
      $display("test buffer done");
      // second reset in mid-run
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      chk_word({7'h0, strobe_oe, strobe, busy, rvalid, dout}, 12'h018);
      reset = 1'b0;
      repeat (20) @(negedge mclk);
      // select low with a running clock: sixteen zeros, then the byte
      vin = 12'h3C3;
      host.xfer({16'h0, 8'h8F, 16'h0}, 40, rx);
      repeat (6) @(negedge mclk);
      chk_word(rx[39:28], 12'h000);
      chk_word(rx[14:3], 12'h3C3);
      chk_word(pop_got(), 12'h3C3);
      frame(8'h8F, 12'hC3C);
      chk_word(pop_got(), 12'hC3C);
      $display("test reset done");
      final_report();
   end
endmodule : adcf_ctrl_tb_top

`default_nettype wire
